// ===== src/str_requester.sv
// Implementation choices: the register addresses and register access over APB.
module str_requester #(
   parameter int unsigned MAX_DEFER = str_pkg::MAX_DEFER,
   parameter int unsigned IOQ_DEPTH = str_pkg::IOQ_DEPTH
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic request_strobe,
   output logic [2:0] request_type_code,
   output logic deferrable_request_flag,
   output logic [7:0] second_clock_upper_address_bits,
   input wire logic busStrobe,
   input wire logic [7:0] first_clock_upper_address_bits,
   input wire logic snoopValid,
   input wire logic snoopPostpone,
   input wire logic modified_line_present,
   input wire logic responseValid,
   input wire logic [2:0] response_status_code,
   output logic snoopOwner
);
   localparam int unsigned SLOT_W = (MAX_DEFER > 1) ? $clog2(MAX_DEFER) : 1;
   localparam int unsigned ENT_W = SLOT_W + 2;
   localparam int unsigned ENT_OWN = SLOT_W + 1;
   localparam int unsigned ENT_REPLY = SLOT_W;
   localparam int unsigned SYNC_W = 16;
   localparam int unsigned CNT_W = str_pkg::CNT_W;

   generate
      if (MAX_DEFER < 1 || MAX_DEFER >= str_pkg::MAX_IDS)
      begin : g_chk
         $error("str_requester supports one to fifteen deferrals");
      end
   endgenerate

   // Whether a given tag carries our agent id and names one of our slots still outstanding
   function automatic logic tagMatch(input logic [7:0] tag, input logic [3:0] agent,
                                     input logic [MAX_DEFER-1:0] pend);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < MAX_DEFER; i++)
         if (tag[str_pkg::ID_W-1:0] == str_pkg::ID_W'(i) && pend[i])
            hit = 1'b1;
      return hit & (tag[str_pkg::TAG_W-1:str_pkg::ID_W] == agent);
   endfunction

   function automatic logic [SLOT_W:0] firstFree(input logic [MAX_DEFER-1:0] busy);
      logic [SLOT_W:0] res;
      res = '0;
      for (int i = MAX_DEFER - 1; i >= 0; i--)
         if (!busy[i])
            res = {1'b1, SLOT_W'(i)};
      return res;
   endfunction

   function automatic logic [3:0] popCount(input logic [MAX_DEFER-1:0] v);
      logic [3:0] n;
      n = '0;
      for (int i = 0; i < MAX_DEFER; i++)
         n = n + 4'(v[i]);
      return n;
   endfunction

   // Pin synchroniser
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   wire [SYNC_W-1:0] busRaw = {busStrobe, first_clock_upper_address_bits, snoopValid, snoopPostpone,
                               modified_line_present, responseValid, response_status_code};
   logic obsStrobe;
   logic [7:0] obsTag;
   logic obsSnoop;
   logic obsPostpone;
   logic obsModified;
   logic obsResp;
   logic [2:0] obsCode;

   assign {obsStrobe, obsTag, obsSnoop, obsPostpone, obsModified, obsResp, obsCode} = sync2_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= busRaw;
         sync2_q <= sync1_q;
      end
   end

   // State
   str_pkg::str_state_type state_q;
   str_pkg::str_state_type state_d;
   logic enable_q;
   logic [3:0] agent_q;
   logic [2:0] curType_q;
   logic curDefer_q;
   logic [SLOT_W-1:0] curSlot_q;
   logic inOrder_q;
   logic [MAX_DEFER-1:0] slotAlloc_q;
   logic [MAX_DEFER-1:0] slotOut_q;
   logic [MAX_DEFER-1:0] slotSnoop_q;
   logic [CNT_W-1:0] doneCnt_q;
   logic [CNT_W-1:0] retryCnt_q;
   logic [CNT_W-1:0] replyCnt_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // In-order queue
   logic [ENT_W-1:0] snoopEnt;
   logic [ENT_W-1:0] headEnt;
   logic ioqFull;
   logic ioqEmpty;
   wire ownPush = (state_q == str_pkg::ST_FIRST);
   wire replyHit = obsStrobe & tagMatch(obsTag, agent_q, slotOut_q);
   wire [SLOT_W-1:0] replySlot = obsTag[SLOT_W-1:0];
   wire ioqPush = ownPush | obsStrobe;
   wire [ENT_W-1:0] ioqPushData = ownPush ? {1'b1, 1'b0, curSlot_q} : {1'b0, replyHit, replySlot};
   wire snoopOwn = obsSnoop & snoopEnt[ENT_OWN];
   wire snoopReply = obsSnoop & snoopEnt[ENT_REPLY];
   wire [SLOT_W-1:0] snoopSlot = snoopEnt[SLOT_W-1:0];
   wire respOwn = obsResp & ~ioqEmpty & headEnt[ENT_OWN];
   wire respReply = obsResp & ~ioqEmpty & headEnt[ENT_REPLY];
   wire [SLOT_W-1:0] headSlot = headEnt[SLOT_W-1:0];
   wire ownRetry = respOwn & (obsCode == str_pkg::RESP_RETRY);
   wire ownDefer = respOwn & (obsCode == str_pkg::RESP_DEFER) & curDefer_q;
   wire ownDone = respOwn & ~ownRetry & ~ownDefer;
   wire replyDone = respReply & (obsCode != str_pkg::RESP_RETRY) & slotSnoop_q[headSlot];

   str_ioq #(
      .DEPTH(IOQ_DEPTH),
      .WIDTH(ENT_W)
   ) u_ioq (
      .clock(clock),
      .sys_rst(sys_rst),
      .push(ioqPush),
      .pushData(ioqPushData),
      .snoopAdv(obsSnoop),
      .pop(obsResp),
      .snoopData(snoopEnt),
      .headData(headEnt),
      .full(ioqFull),
      .empty(ioqEmpty)
   );

   // Register decode
   wire apbSetup = psel & ~penable;
   wire apbAccess = psel & penable;
   wire hitCtrl = (paddr == str_pkg::CTRL_OFS);
   wire hitIssue = (paddr == str_pkg::ISSUE_OFS);
   wire hitStatus = (paddr == str_pkg::STATUS_OFS);
   wire hitCount = (paddr == str_pkg::COUNT_OFS);
   wire hitAny = hitCtrl | hitIssue | hitStatus | hitCount;
   wire issueBad = pwrite & hitIssue & (~enable_q | (state_q != str_pkg::ST_IDLE) | ioqFull);
   wire errSetup = ~hitAny | issueBad;
   wire ctrlWrite = apbAccess & pwrite & hitCtrl & ~pslverr_q;
   wire issueFire = apbAccess & pwrite & hitIssue & ~pslverr_q;
   wire [2:0] issueType = pwdata[str_pkg::ISSUE_TYPE_LSB +: 3];
   wire issueLock = pwdata[str_pkg::ISSUE_LOCK_BIT];
   wire issueReply = pwdata[str_pkg::ISSUE_REPLY_BIT];
   wire issueNoDefer = issueLock | issueReply | (issueType == str_pkg::TYPE_WRITEBACK);
   wire [SLOT_W:0] freeSlot = firstFree(slotAlloc_q | slotOut_q);
   wire issueDefer = pwdata[str_pkg::ISSUE_DEFER_BIT] & ~issueNoDefer & freeSlot[SLOT_W];
   wire [31:0] statusWord = {8'h00,
                             popCount(slotOut_q),
                             {(str_pkg::MAX_IDS - MAX_DEFER){1'b0}},
                             slotOut_q,
                             2'b00,
                             inOrder_q,
                             state_q != str_pkg::ST_IDLE};
   wire [31:0] countWord = {8'h00, replyCnt_q, retryCnt_q, doneCnt_q};
   wire [31:0] ctrlWord = {24'h000000, agent_q, 3'b000, enable_q};
   wire [31:0] readWord = hitCtrl ? ctrlWord :
                          hitStatus ? statusWord :
                          hitCount ? countWord : 32'h00000000;

   assign pready = apbAccess;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q & apbAccess;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end
      else if (apbSetup)
      begin
         prdata_q <= pwrite ? 32'h00000000 : readWord;
         pslverr_q <= errSetup;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         enable_q <= 1'b0;
         agent_q <= 4'h0;
      end
      else if (ctrlWrite)
      begin
         enable_q <= pwdata[str_pkg::CTRL_EN_BIT];
         agent_q <= pwdata[str_pkg::CTRL_AGENT_LSB +: str_pkg::ID_W];
      end
   end

   // Request sequencer
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         str_pkg::ST_IDLE:
         begin
            if (issueFire)
               state_d = str_pkg::ST_FIRST;
         end
         str_pkg::ST_FIRST:
         begin
            state_d = str_pkg::ST_SECOND;
         end
         str_pkg::ST_SECOND:
         begin
            state_d = str_pkg::ST_WAIT;
         end
         str_pkg::ST_WAIT:
         begin
            if (ownRetry)
               state_d = str_pkg::ST_FIRST;
            else if (respOwn)
               state_d = str_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= str_pkg::ST_IDLE;
         curType_q <= 3'h0;
         curDefer_q <= 1'b0;
         curSlot_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (issueFire)
         begin
            curType_q <= issueType;
            curDefer_q <= issueDefer;
            curSlot_q <= freeSlot[SLOT_W-1:0];
         end
      end
   end

   // Request pins, first clock then tag on the second
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         request_strobe <= 1'b0;
         request_type_code <= 3'h0;
         deferrable_request_flag <= 1'b0;
         second_clock_upper_address_bits <= 8'h00;
      end
      else
      begin
         request_strobe <= (state_q == str_pkg::ST_FIRST);
         request_type_code <= (state_q == str_pkg::ST_FIRST) ? curType_q : 3'h0;
         deferrable_request_flag <= (state_q == str_pkg::ST_FIRST) & curDefer_q;
         if (state_q == str_pkg::ST_SECOND)
            second_clock_upper_address_bits <= {agent_q, curDefer_q ? 4'(curSlot_q) : str_pkg::NODEFER_ID};
         else
            second_clock_upper_address_bits <= 8'h00;
      end
   end

   // Snoop result of own request decides in-order completion
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         inOrder_q <= 1'b0;
      else if (snoopOwn)
         inOrder_q <= ~obsPostpone | obsModified;
   end

   // Outstanding slots
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slotAlloc_q <= '0;
         slotOut_q <= '0;
         slotSnoop_q <= '0;
      end
      else
      begin
         for (int i = 0; i < MAX_DEFER; i++)
         begin
            if (issueFire && issueDefer && freeSlot[SLOT_W-1:0] == SLOT_W'(i))
               slotAlloc_q[i] <= 1'b1;
            else if (respOwn && !ownRetry && curSlot_q == SLOT_W'(i))
               slotAlloc_q[i] <= 1'b0;
            if (ownDefer && curSlot_q == SLOT_W'(i))
               slotOut_q[i] <= 1'b1;
            else if (replyDone && headSlot == SLOT_W'(i))
               slotOut_q[i] <= 1'b0;
            if (snoopReply && snoopSlot == SLOT_W'(i))
               slotSnoop_q[i] <= 1'b1;
            else if (replyDone && headSlot == SLOT_W'(i))
               slotSnoop_q[i] <= 1'b0;
         end
      end
   end

   // Reply snoop takes over snoop responsibility
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         snoopOwner <= 1'b0;
      else
         snoopOwner <= snoopReply;
   end

   // Event counters
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         doneCnt_q <= '0;
         retryCnt_q <= '0;
         replyCnt_q <= '0;
      end
      else
      begin
         if (ownDone || replyDone)
            doneCnt_q <= doneCnt_q + 1'b1;
         if (ownRetry)
            retryCnt_q <= retryCnt_q + 1'b1;
         if (replyHit)
            replyCnt_q <= replyCnt_q + 1'b1;
      end
   end

endmodule

// ===== pkg/str_pkg.sv
package str_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ISSUE_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0c;

   // Control fields
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_AGENT_LSB = 4;

   // Issue fields
   localparam int unsigned ISSUE_TYPE_LSB = 0;
   localparam int unsigned ISSUE_LOCK_BIT = 3;
   localparam int unsigned ISSUE_DEFER_BIT = 4;
   localparam int unsigned ISSUE_REPLY_BIT = 5;

   // Status fields
   localparam int unsigned STATUS_BUSY_BIT = 0;
   localparam int unsigned STATUS_INORDER_BIT = 1;
   localparam int unsigned STATUS_SLOT_LSB = 4;
   localparam int unsigned STATUS_CNT_LSB = 20;

   // Counter fields
   localparam int unsigned COUNT_DONE_LSB = 0;
   localparam int unsigned COUNT_RETRY_LSB = 8;
   localparam int unsigned COUNT_REPLY_LSB = 16;

   // Request type and response status encodings
   localparam logic [2:0] TYPE_WRITEBACK = 3'h5;
   localparam logic [2:0] RESP_RETRY = 3'h1;
   localparam logic [2:0] RESP_DEFER = 3'h2;
   localparam logic [2:0] RESP_NODATA = 3'h3;
   localparam logic [2:0] RESP_NORMAL = 3'h5;
   localparam logic [2:0] RESP_IWB = 3'h6;

   // Tag layout
   localparam int unsigned ID_W = 4;
   localparam int unsigned TAG_W = 8;
   localparam logic [3:0] NODEFER_ID = 4'hf;

   // Sizes
   localparam int unsigned MAX_DEFER = 4;
   localparam int unsigned MAX_IDS = 16;
   localparam int unsigned IOQ_DEPTH = 8;
   localparam int unsigned CNT_W = 8;

   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND, ST_WAIT} str_state_type;

endpackage

// ===== src/str_ioq.sv
module str_ioq #(
   parameter int unsigned DEPTH = 8,
   parameter int unsigned WIDTH = 4
)(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic [WIDTH-1:0] pushData,
   input wire logic snoopAdv,
   input wire logic pop,
   output logic [WIDTH-1:0] snoopData,
   output logic [WIDTH-1:0] headData,
   output logic full,
   output logic empty
);
   localparam int unsigned PTR_W = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_chk
         $error("str_ioq depth must be a power of two of at least two");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wrPtr_q;
   logic [PTR_W-1:0] snPtr_q;
   logic [PTR_W-1:0] rdPtr_q;
   logic [PTR_W:0] count_q;
   wire pushOk = push & ~full;
   wire popOk = pop & ~empty;

   assign full = (count_q == (PTR_W + 1)'(DEPTH));
   assign empty = (count_q == '0);
   assign snoopData = mem_q[snPtr_q];
   assign headData = mem_q[rdPtr_q];

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wrPtr_q <= '0;
         snPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (pushOk)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (snoopAdv)
            snPtr_q <= snPtr_q + 1'b1;
         if (popOk)
            rdPtr_q <= rdPtr_q + 1'b1;
         count_q <= count_q + (PTR_W + 1)'(pushOk) - (PTR_W + 1)'(popOk);
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= '0;
      end
      else if (pushOk)
      begin
         mem_q[wrPtr_q] <= pushData;
      end
   end

endmodule

// ===== tb/str_requester_sva.sv
module str_requester_sva (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic request_strobe,
   input wire logic [2:0] request_type_code,
   input wire logic deferrable_request_flag,
   input wire logic [7:0] second_clock_upper_address_bits,
   input wire logic snoopValid,
   input wire logic responseValid,
   input wire logic [2:0] response_status_code,
   input wire logic snoopOwner
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire issueOk = psel && penable && pwrite && paddr == str_pkg::ISSUE_OFS && !pslverr;
   wire ownRetry = responseValid && response_status_code == str_pkg::RESP_RETRY;
   a_pready_access: assert property (pready == (psel && penable))
      else $error("pready differs from access phase");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   a_issue_strobe: assert property (issueOk |-> ##[1:2] request_strobe)
      else $error("no request strobe after issue");
   a_strobe_single: assert property (request_strobe |=> !request_strobe)
      else $error("request strobe longer than one cycle");
   a_type_idle: assert property (!request_strobe |-> request_type_code == 3'h0)
      else $error("request type outside strobe");
   a_wb_nodefer: assert property (request_strobe && request_type_code == str_pkg::TYPE_WRITEBACK
      |-> !deferrable_request_flag)
      else $error("writeback issued deferrable");
   a_tag_defer: assert property (request_strobe && deferrable_request_flag
      |=> second_clock_upper_address_bits[3:0] != str_pkg::NODEFER_ID)
      else $error("deferrable request without slot id");
   a_tag_nodefer: assert property (request_strobe && !deferrable_request_flag
      |=> second_clock_upper_address_bits[3:0] == str_pkg::NODEFER_ID)
      else $error("plain request with slot id");
   a_tag_idle: assert property (!request_strobe |=> second_clock_upper_address_bits == 8'h00)
      else $error("tag outside second clock");
   a_retry_again: assert property (ownRetry |-> ##[3:8] request_strobe)
      else $error("no reissue after retry");
   a_owner_snoop: assert property (snoopOwner |-> $past(snoopValid, 3))
      else $error("snoop owner without reply snoop");
   cover property (responseValid && response_status_code == str_pkg::RESP_DEFER);
   cover property (ownRetry);
   cover property (snoopOwner);
   cover property (request_strobe && !deferrable_request_flag);
endmodule

bind str_requester str_requester_sva u_sva (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .request_strobe(request_strobe),
   .request_type_code(request_type_code), .deferrable_request_flag(deferrable_request_flag),
   .second_clock_upper_address_bits(second_clock_upper_address_bits), .snoopValid(snoopValid),
   .responseValid(responseValid), .response_status_code(response_status_code), .snoopOwner(snoopOwner));

// ===== tb/str_resp_model.sv
module str_resp_model #(
   parameter int unsigned POOL = 4
)(
   input wire logic clock,
   input wire logic request_strobe,
   input wire logic [2:0] request_type_code,
   input wire logic deferrable_request_flag,
   input wire logic [7:0] second_clock_upper_address_bits,
   input wire logic [1:0] mode,
   input wire logic replyGo,
   output logic busStrobe,
   output logic [7:0] first_clock_upper_address_bits,
   output logic snoopValid,
   output logic snoopPostpone,
   output logic modified_line_present,
   output logic responseValid,
   output logic [2:0] response_status_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pool[$];
   logic [7:0] tg;
   logic [2:0] ty;
   logic fl;
   logic retried = 1'b0;
   // Snoop pulse then response pulse; released lines show the inverse
   task automatic phases(input logic post, input logic hit, input logic [2:0] rs);
      repeat (2) @(posedge clock);
      snoopValid <= 1'b1;
      snoopPostpone <= post;
      modified_line_present <= hit;
      @(posedge clock);
      snoopValid <= 1'b0;
      snoopPostpone <= ~post;
      modified_line_present <= ~hit;
      repeat (2) @(posedge clock);
      responseValid <= 1'b1;
      response_status_code <= rs;
      @(posedge clock);
      responseValid <= 1'b0;
      response_status_code <= ~rs;
   endtask
   initial
   begin
      busStrobe = 1'b0;
      first_clock_upper_address_bits = 8'h00;
      snoopValid = 1'b0;
      snoopPostpone = 1'b0;
      modified_line_present = 1'b0;
      responseValid = 1'b0;
      response_status_code = 3'h0;
      forever
      begin
         @(posedge clock);
         if (request_strobe === 1'b1)
         begin
            ty = request_type_code;
            fl = deferrable_request_flag;
            @(posedge clock);
            tg = second_clock_upper_address_bits;
            if (mode == 2'd1 && !retried && ty != str_pkg::TYPE_WRITEBACK)
            begin
               retried = 1'b1;
               phases(1'b1, 1'b0, str_pkg::RESP_RETRY);
            end
            else if (mode == 2'd2 && fl && pool.size() < POOL)
            begin
               pool.push_back(tg);
               phases(1'b1, 1'b0, str_pkg::RESP_DEFER);
            end
            else
            begin
               retried = 1'b0;
               phases(1'b0, mode == 2'd3, mode == 2'd3 ? str_pkg::RESP_IWB : str_pkg::RESP_NORMAL);
            end
         end
         else if (replyGo && pool.size() > 0)
         begin
            tg = pool.pop_front();
            busStrobe <= 1'b1;
            first_clock_upper_address_bits <= tg;
            @(posedge clock);
            busStrobe <= 1'b0;
            first_clock_upper_address_bits <= ~tg;
            phases(1'b0, tg[0], tg[0] ? str_pkg::RESP_IWB : str_pkg::RESP_NORMAL);
         end
      end
   end
endmodule

// ===== tb/str_requester_tb_top.sv
module str_requester_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, replyGo = 1'b0, lastFlag = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, request_strobe, deferrable_request_flag, busStrobe, snoopValid;
   logic snoopPostpone, modified_line_present, responseValid, snoopOwner;
   logic [2:0] request_type_code, response_status_code, t;
   logic [7:0] second_clock_upper_address_bits, first_clock_upper_address_bits;
   logic [1:0] mode = 2'd0;
   logic [2:0] lastType = 3'h0;
   logic [3:0] agent;
   int fail_count = 0, checked = 0, cyc = 0, seed = 99680;
   int nDone = 0, nRetry = 0, nReply = 0, held = 0, owners = 0;
   str_requester dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .request_strobe(request_strobe), .request_type_code(request_type_code),
      .deferrable_request_flag(deferrable_request_flag),
      .second_clock_upper_address_bits(second_clock_upper_address_bits), .busStrobe(busStrobe),
      .first_clock_upper_address_bits(first_clock_upper_address_bits), .snoopValid(snoopValid),
      .snoopPostpone(snoopPostpone), .modified_line_present(modified_line_present),
      .responseValid(responseValid), .response_status_code(response_status_code), .snoopOwner(snoopOwner));
   str_resp_model model (.clock(clock), .request_strobe(request_strobe), .request_type_code(request_type_code),
      .deferrable_request_flag(deferrable_request_flag),
      .second_clock_upper_address_bits(second_clock_upper_address_bits), .mode(mode), .replyGo(replyGo),
      .busStrobe(busStrobe), .first_clock_upper_address_bits(first_clock_upper_address_bits),
      .snoopValid(snoopValid), .snoopPostpone(snoopPostpone), .modified_line_present(modified_line_present),
      .responseValid(responseValid), .response_status_code(response_status_code));
   always #10 clock = ~clock;
   always @(posedge clock)
   begin
      if (request_strobe === 1'b1)
      begin
         lastFlag <= deferrable_request_flag;
         lastType <= request_type_code;
      end
      if (snoopOwner === 1'b1) owners++;
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic counts;
      apb(1'b0, str_pkg::COUNT_OFS, 32'h0);
      cmp("completions", nDone, rd[7:0]);
      cmp("retries", nRetry, rd[15:8]);
      cmp("replies", nReply, rd[23:16]);
      apb(1'b0, str_pkg::STATUS_OFS, 32'h0);
      cmp("outstanding", held, rd[23:20]);
   endtask
   // Expected flag and outcome follow from mode, type, lock, reply bit and slots held
   task automatic step(input logic [1:0] m, input logic [2:0] ty, input logic lk, input logic rp);
      logic f;
      f = !lk && !rp && ty != str_pkg::TYPE_WRITEBACK && held < str_pkg::MAX_DEFER;
      mode <= m;
      apb(1'b1, str_pkg::ISSUE_OFS, {26'h0, rp, 1'b1, lk, ty});
      cmp("issue error", 0, err);
      rd = 32'h1;
      for (int i = 0; i < 60 && rd[0] !== 1'b0; i++) apb(1'b0, str_pkg::STATUS_OFS, 32'h0);
      cmp("deferrable flag", f, lastFlag);
      cmp("request type", ty, lastType);
      if (m == 2'd1 && ty != str_pkg::TYPE_WRITEBACK) nRetry++;
      if (m == 2'd2 && f) held++;
      else nDone++;
      counts();
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      apb(1'b0, str_pkg::CTRL_OFS, 32'h0);
      cmp("ctrl reset", 0, rd);
      counts();
      apb(1'b0, 8'h10, 32'h0);
      cmp("unmapped error", 1, err);
      cmp("unmapped data", 0, rd);
      apb(1'b1, str_pkg::ISSUE_OFS, 32'h12);
      cmp("disabled issue error", 1, err);
      agent = 4'($random(seed));
      apb(1'b1, str_pkg::CTRL_OFS, {24'h0, agent, 4'h1});
      apb(1'b0, str_pkg::CTRL_OFS, 32'h0);
      cmp("ctrl", {24'h0, agent, 4'h1}, rd);
      for (int i = 0; i < 4; i++) step(2'(i), 3'h2, 1'b0, 1'b0);
      step(2'd1, str_pkg::TYPE_WRITEBACK, 1'b0, 1'b0);
      step(2'd1, 3'h0, 1'b1, 1'b0);
      step(2'd2, 3'h1, 1'b0, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         t = 3'($random(seed));
         if (t == str_pkg::TYPE_WRITEBACK) t = 3'h6;
         step(2'd2, t, 1'b0, 1'b0);
      end
      replyGo <= 1'b1;
      nReply = held;
      nDone += held;
      held = 0;
      rd = 32'h0;
      for (int i = 0; i < 60 && rd[7:0] !== 8'(nDone); i++) apb(1'b0, str_pkg::COUNT_OFS, 32'h0);
      counts();
      cmp("snoop ownership", nReply, owners);
      give_verdict();
   end
endmodule
